// >>> rtl/bsg_top.v
// Purpose: program memory port, boot strap and general pins behind AHB-Lite
// Assumes: single word transfers, zero wait state slave
// Notes:   memory cycles are started by firmware writes to the control register
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bsg_consts.vh"
module bsg_top (
  // bus clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // external program memory
  output reg  [15:0] ext_mem_addr,
  output reg         prog_mem_read_n,
  output reg         prog_mem_write_n,
  output reg         prog_mem_select_n,
  input  wire [7:0]  ext_mem_bus_in,
  output reg  [7:0]  ext_mem_bus_out,
  output wire        ext_mem_bus_oe_n,
  output wire        boot_from_ext,
  // strap and pin six
  input  wire        boot_source_strap_in,
  output wire        boot_source_strap_out,
  output wire        boot_source_strap_oe_n,
  output wire        boot_source_strap_pullup,
  output wire        serial_rx,
  // other general pins
  input  wire [14:0] gp_pin_in,
  output wire [14:0] gp_pin_out,
  output wire [14:0] gp_pin_oe_n,
  // test inputs and interrupt
  input  wire [1:0]  test_mode_in_n,
  output wire        irq
);
  //////////////////////////////////////////////////////////////////////////
  // memory cycle states
  localparam ST_IDLE = 2'h0;
  localparam ST_RD   = 2'h1;
  localparam ST_WR   = 2'h2;

  reg  [1:0]  st_r;
  reg  [3:0]  cyc_r;
  reg  [14:0] out_r;
  reg  [14:0] dir_r;
  reg  [6:0]  ien_r;
  reg  [6:0]  iedge_r;
  reg  [6:0]  iclr;
  reg  [1:0]  ctrl_r;
  reg  [15:0] maddr_r;
  reg  [7:0]  mdata_r;
  reg  [7:0]  mrd_r;
  reg  [7:0]  mem_start;
  reg         start_rd;
  reg         start_wr;
  reg         ap_wr_r;
  reg         ap_rd_r;
  reg  [11:0] ap_addr_r;
  wire        boot_ext;
  wire        released;
  wire [14:0] pin_val;
  wire [6:0]  int_stat;
  wire [14:0] pins_in;
  wire [14:0] pins_oe_n;
  wire [14:0] pins_out;
  wire        ap_ok;

  // next values
  reg  [1:0]  st_nxt;
  reg  [3:0]  cyc_nxt;
  reg  [15:0] addr_nxt;
  reg         rd_n_nxt;
  reg         wr_n_nxt;
  reg         sel_n_nxt;
  reg  [7:0]  bus_out_nxt;
  reg  [7:0]  mrd_nxt;
  reg  [14:0] out_nxt;
  reg  [14:0] dir_nxt;
  reg  [6:0]  ien_nxt;
  reg  [6:0]  iedge_nxt;
  reg  [1:0]  ctrl_nxt;
  reg  [15:0] maddr_nxt;
  reg  [7:0]  mdata_nxt;
  reg         oe_n_r;

  function [31:0] bsg_word;
    input [15:0] v;
    begin
      bsg_word = {16'h0000, v};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // boot strap capture and pull-up
  bsg_strap u_strap (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .strap_in        (boot_source_strap_in),
    .strap_pullup_en (boot_source_strap_pullup),
    .boot_ext_r      (boot_ext),
    .strap_released  (released)
  );

  // pin six is the strap pin once released
  assign pins_in = {gp_pin_in[14:6], boot_source_strap_in, gp_pin_in[4:0]};

  // general pins and edge interrupts
  bsg_pins u_pins (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .out_val    (out_r),
    .dir_out    (dir_r),
    .int_en     (ien_r),
    .int_rise   (iedge_r),
    .int_clr    (iclr),
    .pin_in     (pins_in),
    .pin_out    (pins_out),
    .pin_oe_n   (pins_oe_n),
    .pin_val_r  (pin_val),
    .int_stat_r (int_stat)
  );

  assign gp_pin_out  = {pins_out[14:6], 1'b0, pins_out[4:0]};
  assign gp_pin_oe_n = {pins_oe_n[14:6], 1'b1, pins_oe_n[4:0]};
  // strap pin held as input until the strap is released
  assign boot_source_strap_out  = out_r[5];
  assign boot_source_strap_oe_n = pins_oe_n[5] | ~released | ctrl_r[`BSG_BIT_RX_SEL]; // RULE11
  assign serial_rx              = ctrl_r[`BSG_BIT_RX_SEL] ? boot_source_strap_in : 1'b1; // RULE11
  assign boot_from_ext = boot_ext;
  assign irq = |(int_stat & ien_r);
  assign ext_mem_bus_oe_n = oe_n_r;

  //////////////////////////////////////////////////////////////////////////
  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_ok     = hsel & hready & htrans[1];

  // write data phase side effects
  always @* begin
    iclr      = 7'h00;
    start_rd  = 1'b0;
    start_wr  = 1'b0;
    mem_start = 8'h00;
    if (ap_wr_r && ap_addr_r == `BSG_OFF_INT_CLR) begin
      iclr = hwdata[6:0];
    end
    if (ap_wr_r && ap_addr_r == `BSG_OFF_MEM_CTRL && st_r == ST_IDLE) begin
      start_wr  = hwdata[`BSG_BIT_MEM_WR];
      start_rd  = hwdata[`BSG_BIT_MEM_RD] & ~hwdata[`BSG_BIT_MEM_WR];
      mem_start = 8'h01;
    end
  end

  // read mux
  always @* begin
    case (ap_addr_r)
      `BSG_OFF_PIN_IN1:  hrdata = bsg_word({7'h00, boot_ext, pin_val[7:0]}); // RULE8
      `BSG_OFF_PIN_IN2:  hrdata = bsg_word({9'h000, pin_val[14:8]});
      `BSG_OFF_PIN_OUT:  hrdata = bsg_word({1'b0, out_r});
      `BSG_OFF_PIN_DIR:  hrdata = bsg_word({1'b0, dir_r});
      `BSG_OFF_INT_EN:   hrdata = bsg_word({9'h000, ien_r});
      `BSG_OFF_INT_EDGE: hrdata = bsg_word({9'h000, iedge_r});
      `BSG_OFF_INT_STAT: hrdata = bsg_word({9'h000, int_stat});
      `BSG_OFF_MEM_CTRL: hrdata = bsg_word({14'h0000, ctrl_r});
      `BSG_OFF_MEM_ADDR: hrdata = bsg_word(maddr_r);
      `BSG_OFF_MEM_DATA: hrdata = bsg_word({8'h00, mrd_r});
      `BSG_OFF_MEM_STAT: hrdata = bsg_word({12'h000, test_mode_in_n, st_r != ST_IDLE, boot_ext});
      default:           hrdata = 32'h00000000;
    endcase
    // zero outside a read data phase
    if (!ap_rd_r) begin
      hrdata = 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register write decode
  always @* begin
    out_nxt   = out_r;
    dir_nxt   = dir_r;
    ien_nxt   = ien_r;
    iedge_nxt = iedge_r;
    ctrl_nxt  = ctrl_r;
    maddr_nxt = maddr_r;
    mdata_nxt = mdata_r;
    if (ap_wr_r) begin
      case (ap_addr_r)
        `BSG_OFF_PIN_OUT:  out_nxt   = hwdata[14:0];
        `BSG_OFF_PIN_DIR:  dir_nxt   = hwdata[14:0]; // RULE12 RULE13
        `BSG_OFF_INT_EN:   ien_nxt   = hwdata[6:0]; // RULE12
        `BSG_OFF_INT_EDGE: iedge_nxt = hwdata[6:0];
        `BSG_OFF_MEM_CTRL: ctrl_nxt  = hwdata[1:0];
        `BSG_OFF_MEM_ADDR: maddr_nxt = hwdata[15:0];
        `BSG_OFF_MEM_DATA: mdata_nxt = hwdata[7:0];
        // unmapped and read-only offsets ignore writes
        default:           ctrl_nxt  = ctrl_r;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r   <= 1'b0;
      ap_rd_r   <= 1'b0;
      ap_addr_r <= 12'h000;
      out_r     <= 15'h0000;
      dir_r     <= 15'h0000;
      ien_r     <= 7'h00;
      iedge_r   <= 7'h00;
      ctrl_r    <= 2'h0;
      maddr_r   <= 16'h0000;
      mdata_r   <= 8'h00;
    end else begin
      ap_wr_r   <= ap_ok & hwrite;
      ap_rd_r   <= ap_ok & ~hwrite;
      ap_addr_r <= haddr[11:0];
      out_r     <= out_nxt;
      dir_r     <= dir_nxt;
      ien_r     <= ien_nxt;
      iedge_r   <= iedge_nxt;
      ctrl_r    <= ctrl_nxt;
      maddr_r   <= maddr_nxt;
      mdata_r   <= mdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // memory cycle next state
  // strobes and address only move on hclk, so the memory sees clean levels
  always @* begin
    st_nxt      = st_r;
    cyc_nxt     = cyc_r;
    addr_nxt    = ext_mem_addr;
    rd_n_nxt    = prog_mem_read_n;
    wr_n_nxt    = prog_mem_write_n;
    sel_n_nxt   = ctrl_r[`BSG_BIT_STANDBY]; // RULE4
    bus_out_nxt = ext_mem_bus_out;
    mrd_nxt     = mrd_r;
    case (st_r)
      ST_IDLE: begin
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        cyc_nxt  = 4'h0;
        if (mem_start[0] && (start_rd || start_wr)) begin
          addr_nxt    = maddr_r; // RULE1
          bus_out_nxt = mdata_r;
          st_nxt      = start_wr ? ST_WR : ST_RD;
          rd_n_nxt    = ~start_rd; // RULE3
          wr_n_nxt    = ~start_wr; // RULE2
        end
      end
      ST_RD, ST_WR: begin
        if (cyc_r == `BSG_MEM_STROBE_CYC) begin
          if (st_r == ST_RD) begin
            mrd_nxt = ext_mem_bus_in;
          end
          rd_n_nxt = 1'b1; // RULE3
          wr_n_nxt = 1'b1; // RULE2
          st_nxt   = ST_IDLE;
        end else begin
          cyc_nxt = cyc_r + 4'h1;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // memory cycle registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r              <= ST_IDLE;
      cyc_r             <= 4'h0;
      ext_mem_addr      <= 16'h0000;
      prog_mem_read_n   <= 1'b1;
      prog_mem_write_n  <= 1'b1;
      prog_mem_select_n <= 1'b1;
      ext_mem_bus_out   <= 8'h00;
      mrd_r             <= 8'h00;
      oe_n_r            <= 1'b1;
    end else begin
      st_r              <= st_nxt;
      cyc_r             <= cyc_nxt;
      ext_mem_addr      <= addr_nxt;
      prog_mem_read_n   <= rd_n_nxt;
      prog_mem_write_n  <= wr_n_nxt;
      prog_mem_select_n <= sel_n_nxt;
      ext_mem_bus_out   <= bus_out_nxt;
      mrd_r             <= mrd_nxt;
      oe_n_r            <= (st_nxt != ST_WR);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/bsg_consts.vh
// Purpose: constants for the boot strap, program memory port and general pin block
// Assumes: 25 MHz hclk, word registers on AHB-Lite
// Notes:   offsets are byte addresses
// How it works
// RULE1 - every program memory fetch or store puts a 16-bit address on the memory address pins.
// RULE2 - the program memory write strobe is low only while a write is under way.
// RULE3 - the program memory read strobe is low only while a read is under way.
// RULE4 - the program memory select is low except while the chip is in standby; the code also holds it high while chip reset is held.
// RULE5 - the strap pin pull-up is on while chip reset is held.
// RULE6 - the pull-up goes off a few clocks after reset release, not at the release itself.
// RULE7 - the strap level is caught at reset release and picks internal or external code memory.
// RULE8 - the caught boot source is readable as a bit of the first pin-input register.
// RULE9 - a low strap sends code fetches to the external memory bus, whose memory the board fits.
// RULE10 - a high or floating strap keeps code fetches in internal memory.
// RULE11 - after release the strap pin serves as general pin six or as a serial receive input.
// RULE12 - pins one to seven each act as input, edge interrupt input or output.
// RULE13 - pins eight to fifteen act only as input or output.
// RULE14 - the system holds chip reset low for at least one microsecond.
// RULE15 - the board ties both test inputs high for normal operation.
// RULE16 - an enabled pin edge sets a sticky pending flag that firmware clears.
`ifndef BSG_CONSTS_VH
`define BSG_CONSTS_VH
`define BSG_OFF_PIN_IN1     12'h000
`define BSG_OFF_PIN_IN2     12'h004
`define BSG_OFF_PIN_OUT     12'h008
`define BSG_OFF_PIN_DIR     12'h00c
`define BSG_OFF_INT_EN      12'h010
`define BSG_OFF_INT_EDGE    12'h014
`define BSG_OFF_INT_STAT    12'h018
`define BSG_OFF_INT_CLR     12'h01c
`define BSG_OFF_MEM_CTRL    12'h020
`define BSG_OFF_MEM_ADDR    12'h024
`define BSG_OFF_MEM_DATA    12'h028
`define BSG_OFF_MEM_STAT    12'h02c
`define BSG_BIT_BOOT_SRC    8
`define BSG_BIT_RX_SEL      0
`define BSG_BIT_STANDBY     1
`define BSG_BIT_MEM_WR      2
`define BSG_BIT_MEM_RD      3
`define BSG_PULLUP_HOLD     4'h4
`define BSG_MEM_STROBE_CYC  4'h3
`define BSG_RESET_MIN_NS    1000
`define BSG_CLK_NS          40
`endif

// >>> rtl/bsg_strap.v
// Purpose: strap pull-up control and boot source capture
// Assumes: hresetn is the chip reset
// Notes:   capture happens on the first clock after release
`timescale 1ns/1ps
`default_nettype none
`include "bsg_consts.vh"
module bsg_strap (
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // strap pin
  input  wire       strap_in,
  output wire       strap_pullup_en,
  // result
  output reg        boot_ext_r,
  output wire       strap_released
);
  reg [3:0] hold_cnt_r;
  reg       caught_r;
  reg       pu_r;

  assign strap_pullup_en = pu_r;
  assign strap_released  = ~pu_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pu_r       <= 1'b1; // RULE5
      hold_cnt_r <= 4'h0;
      caught_r   <= 1'b0;
      boot_ext_r <= 1'b0;
    end else begin
      if (!caught_r) begin
        caught_r   <= 1'b1;
        boot_ext_r <= ~strap_in; // RULE7 RULE9 RULE10
      end
      if (pu_r) begin
        if (hold_cnt_r == `BSG_PULLUP_HOLD) begin
          pu_r <= 1'b0; // RULE6
        end else begin
          hold_cnt_r <= hold_cnt_r + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/bsg_pins.v
// Purpose: fifteen general pins with edge interrupts on pins one to seven
// Assumes: pin inputs synchronous to hclk
// Notes:   bit 0 is pin one; output enables are active low
`timescale 1ns/1ps
`default_nettype none
`include "bsg_consts.vh"
module bsg_pins (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // configuration
  input  wire [14:0] out_val,
  input  wire [14:0] dir_out,
  input  wire [6:0]  int_en,
  input  wire [6:0]  int_rise,
  input  wire [6:0]  int_clr,
  // pins
  input  wire [14:0] pin_in,
  output wire [14:0] pin_out,
  output wire [14:0] pin_oe_n,
  // status
  output reg  [14:0] pin_val_r,
  output reg  [6:0]  int_stat_r
);
  wire [6:0] rise;
  wire [6:0] fall;
  wire [6:0] hit;

  assign pin_out  = out_val;
  assign pin_oe_n = ~dir_out; // RULE12 RULE13
  assign rise = pin_in[6:0] & ~pin_val_r[6:0];
  assign fall = ~pin_in[6:0] & pin_val_r[6:0];
  // only pins one to seven have edge detection
  assign hit  = int_en & ~dir_out[6:0] & ((int_rise & rise) | (~int_rise & fall)); // RULE12

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_val_r  <= 15'h0000;
      int_stat_r <= 7'h00;
    end else begin
      pin_val_r  <= pin_in;
      int_stat_r <= (int_stat_r & ~int_clr) | hit; // RULE16
    end
  end
endmodule
`default_nettype wire

// >>> bench/bsg_mem_model.sv
// Purpose: external program memory seen from the board
// Assumes: byte wide, decodes the low address byte only
// Notes:   a released data bus shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module bsg_mem_model (
  // memory pins
  input  wire logic [15:0] addr,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  wdata,
  output var  logic [7:0]  rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] last;
  initial begin
    last = 8'h00;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  // take the byte once strobe, address and bus have settled
  always @(negedge wr_n) begin
    #1;
    mem[addr[7:0]] = wdata;
  end
  always @* if (!rd_n) last = mem[addr[7:0]];
  assign rdata = rd_n ? ~last : last;
endmodule
`default_nettype wire

// >>> bench/bsg_top_properties.sv
// Purpose: port checker for bsg_top
// Assumes: one clock, async active low reset
// Notes:   cnt_r counts edges since reset release
`timescale 1ns/1ps
`default_nettype none
module bsg_chk (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // watched ports
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] ext_mem_addr,
  input wire logic        prog_mem_read_n,
  input wire logic        prog_mem_write_n,
  input wire logic        ext_mem_bus_oe_n,
  input wire logic        boot_from_ext,
  input wire logic        boot_source_strap_in,
  input wire logic        boot_source_strap_oe_n,
  input wire logic        boot_source_strap_pullup,
  input wire logic        serial_rx
);
  logic [2:0] cnt_r;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) cnt_r <= 3'h0;
    else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence wr_low4; !prog_mem_write_n [*4] ##1 prog_mem_write_n; endsequence
  sequence rd_low4; !prog_mem_read_n [*4] ##1 prog_mem_read_n; endsequence
  sequence busy2; !(prog_mem_read_n & prog_mem_write_n) [*2]; endsequence
  wr_pulse_len_a: assert property ($fell(prog_mem_write_n) |-> wr_low4)
    else $error("write strobe length");
  rd_pulse_len_a: assert property ($fell(prog_mem_read_n) |-> rd_low4)
    else $error("read strobe length");
  strobe_excl_a: assert property (prog_mem_read_n | prog_mem_write_n)
    else $error("both strobes low");
  addr_hold_a: assert property (busy2 |-> $stable(ext_mem_addr))
    else $error("address moved in cycle");
  read_no_drive_a: assert property (!prog_mem_read_n |-> ext_mem_bus_oe_n)
    else $error("bus driven in read");
  pullup_time_a: assert property (boot_source_strap_pullup == (cnt_r < 3'h5))
    else $error("pull-up timing");
  boot_catch_a: assert property (cnt_r == 3'h1 |-> boot_from_ext == !$past(boot_source_strap_in))
    else $error("strap capture");
  boot_hold_a: assert property (cnt_r > 3'h1 |-> $stable(boot_from_ext))
    else $error("boot source moved");
  rx_idle_a: assert property (!boot_source_strap_oe_n |-> serial_rx)
    else $error("rx not idle");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bad bus answer");
endmodule
bind bsg_top bsg_chk chk_u (.hclk, .hresetn, .hreadyout, .hresp, .ext_mem_addr,
  .prog_mem_read_n, .prog_mem_write_n, .ext_mem_bus_oe_n, .boot_from_ext,
  .boot_source_strap_in, .boot_source_strap_oe_n, .boot_source_strap_pullup, .serial_rx);
`default_nettype wire

// >>> bench/bsg_top_tb.sv
// Purpose: self-checking bench for bsg_top
// Assumes: zero wait ahb-lite slave, 25 MHz hclk
// Notes:   seeded random data and pin values
`timescale 1ns/1ps
`default_nettype none
module bsg_top_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, t, a, d;
  logic [1:0]  htrans = 2'h0, test_mode_in_n = 2'h3;
  logic [2:0]  hsize = 3'h2;
  logic [14:0] pin_drv = 15'h0;
  logic [15:0] seen_a = 16'h0;
  logic [7:0]  sh [0:255];
  logic        strap_drv = 1'b0;
  int          n_fail = 0, compares = 0;
  wire logic        hreadyout, hresp, prog_mem_read_n, prog_mem_write_n, prog_mem_select_n;
  wire logic        ext_mem_bus_oe_n, boot_from_ext, boot_source_strap_in, boot_source_strap_out;
  wire logic        boot_source_strap_oe_n, boot_source_strap_pullup, serial_rx, irq;
  wire logic [31:0] hrdata;
  wire logic [15:0] ext_mem_addr;
  wire logic [7:0]  ext_mem_bus_in, ext_mem_bus_out, mdata;
  wire logic [14:0] gp_pin_in, gp_pin_out, gp_pin_oe_n;
  assign ext_mem_bus_in = ext_mem_bus_oe_n ? mdata : ext_mem_bus_out;
  assign boot_source_strap_in = boot_source_strap_oe_n ? strap_drv : boot_source_strap_out;
  assign gp_pin_in = (gp_pin_oe_n & pin_drv) | (~gp_pin_oe_n & gp_pin_out);
  bsg_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ext_mem_addr, .prog_mem_read_n,
    .prog_mem_write_n, .prog_mem_select_n, .ext_mem_bus_in, .ext_mem_bus_out,
    .ext_mem_bus_oe_n, .boot_from_ext, .boot_source_strap_in, .boot_source_strap_out,
    .boot_source_strap_oe_n, .boot_source_strap_pullup, .serial_rx, .gp_pin_in,
    .gp_pin_out, .gp_pin_oe_n, .test_mode_in_n, .irq);
  bsg_mem_model mem_u (.addr(ext_mem_addr), .rd_n(prog_mem_read_n),
    .wr_n(prog_mem_write_n), .wdata(ext_mem_bus_in), .rdata(mdata));
  always #20 hclk = ~hclk;
  always @(posedge hclk) if (!(prog_mem_read_n & prog_mem_write_n)) seen_a <= ext_mem_addr;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] init_b(input logic [7:0] x);
    return x ^ 8'h5a;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    t = hrdata;
  endtask
  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask
  task automatic rst(input logic s);
    strap_drv <= s;
    hresetn <= 1'b0;
    repeat (25) @(posedge hclk);
    chk(boot_source_strap_pullup, 1'b1);
    chk(prog_mem_select_n, 1'b1);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(boot_from_ext, !s);
    bus(1'b0, 32'h0, 32'h0);
    chk(t[8], !s);
  endtask
  task automatic mop(input logic [31:0] k);
    bus(1'b1, 32'h24, a);
    bus(1'b1, 32'h28, d);
    bus(1'b1, 32'h20, k);
    for (int n = 0; n < 20 && (n == 0 || t[1]); n++)
      bus(1'b0, 32'h2c, 32'h0);
    chk(t[1], 1'b0);
    chk(seen_a, a[15:0]);
  endtask
  task automatic stop_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hcd78));
    for (int i = 0; i < 256; i++) sh[i] = init_b(8'(i));
    rst(1'b0);
    rst(1'b1);
    chk(prog_mem_select_n, 1'b0);
    bus(1'b1, 32'h20, 32'h2);
    settle();
    chk(prog_mem_select_n, 1'b1);
    for (int i = 0; i < 8; i++) begin
      a = $urandom;
      d = $urandom;
      mop(32'h4);
      sh[a[7:0]] = d[7:0];
      a = a ^ {24'h0, 7'h0, i[0]};
      mop(32'h8);
      bus(1'b0, 32'h28, 32'h0);
      chk(t[7:0], sh[a[7:0]]);
    end
    d = $urandom;
    bus(1'b1, 32'h8, d);
    bus(1'b1, 32'hc, 32'h7fdf);
    settle();
    chk(gp_pin_out, d[14:0] & 15'h7fdf);
    chk(gp_pin_oe_n, 15'h0020);
    bus(1'b1, 32'hc, 32'h20);
    bus(1'b1, 32'h8, 32'h20);
    settle();
    chk({boot_source_strap_oe_n, boot_source_strap_out, serial_rx}, 3'h3);
    strap_drv <= 1'b0;
    bus(1'b1, 32'h20, 32'h1);
    settle();
    chk({boot_source_strap_oe_n, serial_rx}, 2'h2);
    d = $urandom;
    pin_drv <= d[14:0];
    bus(1'b1, 32'hc, 32'h0);
    settle();
    bus(1'b0, 32'h0, 32'h0);
    chk(t[7:0] & 8'hdf, d[7:0] & 8'hdf);
    bus(1'b0, 32'h4, 32'h0);
    chk(t[6:0], d[14:8]);
    pin_drv <= 15'h0;
    bus(1'b1, 32'h14, 32'hf);
    bus(1'b1, 32'h10, 32'h5f);
    bus(1'b1, 32'h1c, 32'h7f);
    pin_drv <= 15'h7f7f;
    settle();
    bus(1'b0, 32'h18, 32'h0);
    chk(irq, 1'b1);
    chk(t, 32'hf);
    pin_drv <= 15'h0;
    settle();
    bus(1'b0, 32'h18, 32'h0);
    chk(t, 32'h5f);
    bus(1'b1, 32'h10, 32'h0);
    settle();
    chk(irq, 1'b0);
    bus(1'b1, 32'h1c, 32'h7f);
    pin_drv <= 15'h7f;
    settle();
    bus(1'b0, 32'h18, 32'h0);
    chk(t, 32'h0);
    bus(1'b0, 32'h2c, 32'h0);
    chk(t[3:2], 2'h3);
    bus(1'b0, 32'h100, 32'h0);
    chk(t, 32'h0);
    stop_test();
  end
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
